// ==== audio_adc_consts.svh ====
//Contract
//- Eight-bit page pointer, reset zero, selects page
//- Writing reset bit restores defaults, then self-clears
//- Supply bit picks external rail or regulator
//- Reference quick-charge time 3.5/10/50/100 ms
//- Broadcast bit adds fixed broadcast target address
//- Sleep bit zero keeps device asleep
//- Input capacitor charge time 2.5/12.5/25/50 ms
//- Format field: multiplexed, I2S, left-justified, reserved
//- Slot word length 16/20/24/32, default 32
//- Bits invert frame-sync and bit-clock polarity
//- Late transmit edge delays output half cycle
//- Unused cycles drive zero or high-impedance
//- LSB full cycle or first half only
//- Bus keeper mode: never, always, LSB, LSB+half
//- Slot zero MSB offset of 0 to 31 cycles
//- Daisy chain only while input mixing disabled
//- Bus error detection on while bit five clear
//- Resume-off bit keeps device down after error
//- Page zero selected after power-up and reset
//- Mix attenuation 0/6/12/18 dB on serial input
//- Mix invert bit inverts serial input data
`ifndef AUDIO_ADC_CONSTS_SVH
`define AUDIO_ADC_CONSTS_SVH

`define PAGE_SELECT_ADDR 8'h00
`define SOFT_RESET_ADDR 8'h01
`define SLEEP_SUPPLY_ADDR 8'h02
`define INPUT_CHARGE_ADDR 8'h05
`define SERIAL_FORMAT_ADDR 8'h07
`define SERIAL_OUTPUT_ADDR 8'h08
`define SERIAL_ERROR_ADDR 8'h09
`define SERIAL_MIX_ADDR 8'h0a

`define PAGE_SELECT_RST 8'h00
`define SLEEP_SUPPLY_RST 8'h00
`define INPUT_CHARGE_RST 8'h05
`define SERIAL_FORMAT_RST 8'h30
`define SERIAL_OUTPUT_RST 8'h00
`define SERIAL_ERROR_RST 8'h00
`define SERIAL_MIX_RST 8'h00

`define SLEEP_SUPPLY_WMASK 8'hfd
`define INPUT_CHARGE_WMASK 8'h3f
`define SERIAL_ERROR_WMASK 8'hb8
`define SERIAL_MIX_WMASK 8'hf8
`define SOFT_RESET_BIT 0

`define BROADCAST_ADDR 7'h4c

`define CYCLES_PER_US 40
`define REF_CHARGE0_US 3500
`define REF_CHARGE1_US 10000
`define REF_CHARGE2_US 50000
`define REF_CHARGE3_US 100000
`define IN_CHARGE0_US 2500
`define IN_CHARGE1_US 12500
`define IN_CHARGE2_US 25000
`define IN_CHARGE3_US 50000

`endif

// ==== audio_adc_pkg.sv ====
package audio_adc_pkg;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_REG_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } bus_state_type;

  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    bus_state_type state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] regAddr;
    logic readMode;
    logic nack;
    logic sdaOe;
    logic lowDrive;
    logic [7:0] pageSel;
    logic [7:0] sleepReg;
    logic [7:0] shdnReg;
    logic [7:0] fmtReg;
    logic [7:0] outReg;
    logic [7:0] errReg;
    logic [7:0] mixReg;
    logic daisyEff;
    logic softResetPulse;
    logic [21:0] refTimer;
    logic [21:0] inTimer;
    logic refCharging;
    logic inCharging;
  } regs_state_type;

endpackage

// ==== audio_adc_config_regs_low.sv ====
`timescale 1ns/100ps
`include "audio_adc_consts.svh"

module audio_adc_config_regs_low #(
  parameter logic [6:0] TARGET_ADDR = 7'h4e, // Arbitrary value
  parameter int unsigned REF_CYC0 = `REF_CHARGE0_US * `CYCLES_PER_US,
  parameter int unsigned REF_CYC1 = `REF_CHARGE1_US * `CYCLES_PER_US,
  parameter int unsigned REF_CYC2 = `REF_CHARGE2_US * `CYCLES_PER_US,
  parameter int unsigned REF_CYC3 = `REF_CHARGE3_US * `CYCLES_PER_US,
  parameter int unsigned IN_CYC0 = `IN_CHARGE0_US * `CYCLES_PER_US,
  parameter int unsigned IN_CYC1 = `IN_CHARGE1_US * `CYCLES_PER_US,
  parameter int unsigned IN_CYC2 = `IN_CHARGE2_US * `CYCLES_PER_US,
  parameter int unsigned IN_CYC3 = `IN_CHARGE3_US * `CYCLES_PER_US
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] pageSelect,
  output logic softResetPulse,
  output logic analogSupplySource,
  output logic [1:0] refChargeTime,
  output logic broadcastEnable,
  output logic awakeNSleep,
  output logic refCharging,
  output logic [1:0] inputCapChargeTime,
  output logic inputCharging,
  output logic [1:0] frameFormat,
  output logic [1:0] slotWordLength,
  output logic frameSyncInvert,
  output logic bitClockInvert,
  output logic txLateEdge,
  output logic txIdleHiZ,
  output logic lsbHalfCycle,
  output logic [1:0] keeperMode,
  output logic [4:0] msbOffset,
  output logic daisyChain,
  output logic busErrorDetectOff,
  output logic faultResumeOff,
  output logic [1:0] mixSelect,
  output logic [1:0] mixAttenuation,
  output logic inputMixInvert
);

  audio_adc_pkg::regs_state_type s;
  audio_adc_pkg::regs_state_type n;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic addrHit;
  logic [7:0] rdData;

  // Edges use only the second and third stages of each synchroniser
  assign startSeen = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
  assign stopSeen = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
  assign sclRise = s.sclSync & ~s.sclPrev;
  assign sclFall = ~s.sclSync & s.sclPrev;
  assign addrHit = (s.shift[7:1] == TARGET_ADDR) ||
                   (s.sleepReg[2] && s.shift[7:1] == `BROADCAST_ADDR);

  function automatic logic [21:0] pick(input logic [1:0] code, input int unsigned c0,
                                       input int unsigned c1, input int unsigned c2,
                                       input int unsigned c3);
    logic [21:0] r;
    r = 22'(c0);
    if (code == 2'd1) begin
      r = 22'(c1);
    end else if (code == 2'd2) begin
      r = 22'(c2);
    end else if (code == 2'd3) begin
      r = 22'(c3);
    end
    return r;
  endfunction

  // Register zero answers on every page; the rest only on page zero
  always_comb begin
    rdData = 8'h00;
    if (s.regAddr == `PAGE_SELECT_ADDR) begin
      rdData = s.pageSel;
    end else if (s.pageSel != 8'h00) begin
      rdData = 8'h00;
    end else if (s.regAddr == `SOFT_RESET_ADDR) begin
      rdData = 8'h00;
    end else if (s.regAddr == `SLEEP_SUPPLY_ADDR) begin
      rdData = s.sleepReg;
    end else if (s.regAddr == `INPUT_CHARGE_ADDR) begin
      rdData = s.shdnReg;
    end else if (s.regAddr == `SERIAL_FORMAT_ADDR) begin
      rdData = s.fmtReg;
    end else if (s.regAddr == `SERIAL_OUTPUT_ADDR) begin
      rdData = s.outReg;
    end else if (s.regAddr == `SERIAL_ERROR_ADDR) begin
      rdData = s.errReg;
    end else if (s.regAddr == `SERIAL_MIX_ADDR) begin
      rdData = s.mixReg;
    end
  end

  always_comb begin
    n = s;
    n.sclMeta = scl;
    n.sclSync = s.sclMeta;
    n.sclPrev = s.sclSync;
    n.sdaMeta = sdaIn;
    n.sdaSync = s.sdaMeta;
    n.sdaPrev = s.sdaSync;
    n.softResetPulse = 1'b0;
    n.lowDrive = 1'b0;
    if (sclRise && s.state != audio_adc_pkg::BUS_IDLE) begin
      n.bitCnt = s.bitCnt + 4'd1;
      if (s.state == audio_adc_pkg::BUS_ADDR || s.state == audio_adc_pkg::BUS_REG ||
          s.state == audio_adc_pkg::BUS_WDATA) begin
        n.shift = {s.shift[6:0], s.sdaSync};
      end
      if (s.state == audio_adc_pkg::BUS_RDATA_ACK) begin
        n.nack = s.sdaSync;
      end
    end
    if (stopSeen) begin
      n.state = audio_adc_pkg::BUS_IDLE;
      n.sdaOe = 1'b0;
    end else if (startSeen) begin
      n.state = audio_adc_pkg::BUS_ADDR;
      n.bitCnt = 4'd0;
      n.sdaOe = 1'b0;
    end else if (sclFall) begin
      case (s.state)
        audio_adc_pkg::BUS_ADDR: begin
          if (s.bitCnt == 4'd8) begin
            if (addrHit) begin
              n.readMode = s.shift[0];
              n.sdaOe = 1'b1;
              n.state = audio_adc_pkg::BUS_ADDR_ACK;
            end else begin
              n.state = audio_adc_pkg::BUS_IDLE;
            end
          end
        end
        audio_adc_pkg::BUS_ADDR_ACK: begin
          n.bitCnt = 4'd0;
          if (s.readMode) begin
            n.shift = rdData;
            n.sdaOe = ~rdData[7];
            n.state = audio_adc_pkg::BUS_RDATA;
          end else begin
            n.sdaOe = 1'b0;
            n.state = audio_adc_pkg::BUS_REG;
          end
        end
        audio_adc_pkg::BUS_REG: begin
          if (s.bitCnt == 4'd8) begin
            n.regAddr = s.shift;
            n.sdaOe = 1'b1;
            n.state = audio_adc_pkg::BUS_REG_ACK;
          end
        end
        audio_adc_pkg::BUS_REG_ACK, audio_adc_pkg::BUS_WDATA_ACK: begin
          n.sdaOe = 1'b0;
          n.bitCnt = 4'd0;
          n.state = audio_adc_pkg::BUS_WDATA;
        end
        audio_adc_pkg::BUS_WDATA: begin
          if (s.bitCnt == 4'd8) begin
            n.sdaOe = 1'b1;
            n.state = audio_adc_pkg::BUS_WDATA_ACK;
            n.regAddr = s.regAddr + 8'd1;
            if (s.regAddr == `PAGE_SELECT_ADDR) begin
              n.pageSel = s.shift;
            end else if (s.pageSel != 8'h00) begin
              n.pageSel = s.pageSel;
            end else if (s.regAddr == `SOFT_RESET_ADDR) begin
              if (s.shift[`SOFT_RESET_BIT]) begin
                // Bit is never stored, so it reads back cleared
                n.softResetPulse = 1'b1;
                n.pageSel = `PAGE_SELECT_RST;
                n.sleepReg = `SLEEP_SUPPLY_RST;
                n.shdnReg = `INPUT_CHARGE_RST;
                n.fmtReg = `SERIAL_FORMAT_RST;
                n.outReg = `SERIAL_OUTPUT_RST;
                n.errReg = `SERIAL_ERROR_RST;
                n.mixReg = `SERIAL_MIX_RST;
              end
            end else if (s.regAddr == `SLEEP_SUPPLY_ADDR) begin
              n.sleepReg = (s.sleepReg & ~`SLEEP_SUPPLY_WMASK) |
                           (s.shift & `SLEEP_SUPPLY_WMASK);
            end else if (s.regAddr == `INPUT_CHARGE_ADDR) begin
              n.shdnReg = (s.shdnReg & ~`INPUT_CHARGE_WMASK) |
                          (s.shift & `INPUT_CHARGE_WMASK);
            end else if (s.regAddr == `SERIAL_FORMAT_ADDR) begin
              n.fmtReg = s.shift;
            end else if (s.regAddr == `SERIAL_OUTPUT_ADDR) begin
              n.outReg = s.shift;
            end else if (s.regAddr == `SERIAL_ERROR_ADDR) begin
              n.errReg = (s.errReg & ~`SERIAL_ERROR_WMASK) |
                         (s.shift & `SERIAL_ERROR_WMASK);
            end else if (s.regAddr == `SERIAL_MIX_ADDR) begin
              n.mixReg = (s.mixReg & ~`SERIAL_MIX_WMASK) |
                         (s.shift & `SERIAL_MIX_WMASK);
            end
          end
        end
        audio_adc_pkg::BUS_RDATA: begin
          if (s.bitCnt == 4'd8) begin
            n.sdaOe = 1'b0;
            n.regAddr = s.regAddr + 8'd1;
            n.state = audio_adc_pkg::BUS_RDATA_ACK;
          end else begin
            n.shift = {s.shift[6:0], 1'b0};
            n.sdaOe = ~s.shift[6];
          end
        end
        audio_adc_pkg::BUS_RDATA_ACK: begin
          n.bitCnt = 4'd0;
          if (s.nack) begin
            n.state = audio_adc_pkg::BUS_IDLE;
          end else begin
            n.shift = rdData;
            n.sdaOe = ~rdData[7];
            n.state = audio_adc_pkg::BUS_RDATA;
          end
        end
        default: begin
          n.state = audio_adc_pkg::BUS_IDLE;
        end
      endcase
    end
    // Chain mode is withheld while input mixing is on
    n.daisyEff = n.errReg[7] & (n.mixReg[7:6] == 2'd0);
    // Quick-charge starts when leaving sleep; sleep aborts it
    if (!n.sleepReg[0]) begin
      n.refCharging = 1'b0;
      n.inCharging = 1'b0;
      n.refTimer = 22'd0;
      n.inTimer = 22'd0;
    end else if (!s.sleepReg[0]) begin
      n.refCharging = 1'b1;
      n.inCharging = 1'b1;
      n.refTimer = pick(n.sleepReg[4:3], REF_CYC0, REF_CYC1, REF_CYC2, REF_CYC3);
      n.inTimer = pick(n.shdnReg[5:4], IN_CYC0, IN_CYC1, IN_CYC2, IN_CYC3);
    end else begin
      if (s.refTimer != 22'd0) begin
        n.refTimer = s.refTimer - 22'd1;
      end
      if (s.inTimer != 22'd0) begin
        n.inTimer = s.inTimer - 22'd1;
      end
      n.refCharging = (s.refTimer > 22'd1);
      n.inCharging = (s.inTimer > 22'd1);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.sclMeta <= 1'b1;
      s.sclSync <= 1'b1;
      s.sclPrev <= 1'b1;
      s.sdaMeta <= 1'b1;
      s.sdaSync <= 1'b1;
      s.sdaPrev <= 1'b1;
      s.state <= audio_adc_pkg::BUS_IDLE;
      s.pageSel <= `PAGE_SELECT_RST;
      s.sleepReg <= `SLEEP_SUPPLY_RST;
      s.shdnReg <= `INPUT_CHARGE_RST;
      s.fmtReg <= `SERIAL_FORMAT_RST;
      s.outReg <= `SERIAL_OUTPUT_RST;
      s.errReg <= `SERIAL_ERROR_RST;
      s.mixReg <= `SERIAL_MIX_RST;
    end else begin
      s <= n;
    end
  end

  assign sdaOut = s.lowDrive;
  assign sdaOe = s.sdaOe;
  assign pageSelect = s.pageSel;
  assign softResetPulse = s.softResetPulse;
  assign analogSupplySource = s.sleepReg[7];
  assign refChargeTime = s.sleepReg[4:3];
  assign broadcastEnable = s.sleepReg[2];
  assign awakeNSleep = s.sleepReg[0];
  assign refCharging = s.refCharging;
  assign inputCapChargeTime = s.shdnReg[5:4];
  assign inputCharging = s.inCharging;
  assign frameFormat = s.fmtReg[7:6];
  assign slotWordLength = s.fmtReg[5:4];
  assign frameSyncInvert = s.fmtReg[3];
  assign bitClockInvert = s.fmtReg[2];
  assign txLateEdge = s.fmtReg[1];
  assign txIdleHiZ = s.fmtReg[0];
  assign lsbHalfCycle = s.outReg[7];
  assign keeperMode = s.outReg[6:5];
  assign msbOffset = s.outReg[4:0];
  assign daisyChain = s.daisyEff;
  assign busErrorDetectOff = s.errReg[5];
  assign faultResumeOff = s.errReg[4];
  assign mixSelect = s.mixReg[7:6];
  assign mixAttenuation = s.mixReg[5:4];
  assign inputMixInvert = s.mixReg[3];

endmodule // audio_adc_config_regs_low

// ==== audio_adc_config_regs_low_asserts.sv ====
`timescale 1ns/100ps

module audio_adc_config_regs_low_asserts #(
  parameter int unsigned REF_CYC0 = 20, REF_CYC1 = 40, REF_CYC2 = 60, REF_CYC3 = 80,
  parameter int unsigned IN_CYC0 = 30, IN_CYC1 = 50, IN_CYC2 = 70, IN_CYC3 = 90
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sdaOe,
  input wire logic [7:0] pageSelect,
  input wire logic softResetPulse,
  input wire logic [1:0] refChargeTime,
  input wire logic awakeNSleep,
  input wire logic refCharging,
  input wire logic [1:0] inputCapChargeTime,
  input wire logic inputCharging,
  input wire logic [1:0] frameFormat,
  input wire logic [1:0] slotWordLength,
  input wire logic daisyChain,
  input wire logic [1:0] mixSelect
);
  int unsigned refCnt;
  int unsigned inCnt;
  logic [1:0] refCode;
  logic [1:0] inCode;

  function automatic int unsigned lim(logic [1:0] c, int unsigned a, b, d, e);
    return (c == 2'd0) ? a : (c == 2'd1) ? b : (c == 2'd2) ? d : e;
  endfunction

  // Code latched at the first charging cycle, as the design uses the start codes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refCnt <= 0;
      inCnt <= 0;
      refCode <= 2'b00;
      inCode <= 2'b00;
    end else begin
      refCnt <= refCharging ? refCnt + 1 : 0;
      inCnt <= inputCharging ? inCnt + 1 : 0;
      if (refCharging && refCnt == 0) refCode <= refChargeTime;
      if (inputCharging && inCnt == 0) inCode <= inputCapChargeTime;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_reset_pulse; softResetPulse |=> !softResetPulse; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_reset_page;
    softResetPulse |-> ##[0:2] (pageSelect == 8'h00 && frameFormat == 2'b00 &&
      slotWordLength == 2'b11 && !awakeNSleep);
  endproperty
  a_reset_page: assert property (p_reset_page) else $error("defaults not restored");
  // Output and mix field come from the same register edge
  property p_daisy; daisyChain |-> mixSelect == 2'b00; endproperty
  a_daisy: assert property (p_daisy) else $error("daisy chain with mixing on");
  property p_ref_start; $rose(refCharging) |-> awakeNSleep; endproperty
  a_ref_start: assert property (p_ref_start) else $error("charge while asleep");
  property p_ref_sleep; !awakeNSleep ##1 !awakeNSleep |-> !refCharging; endproperty
  a_ref_sleep: assert property (p_ref_sleep) else $error("ref charge in sleep");
  property p_in_sleep; !awakeNSleep ##1 !awakeNSleep |-> !inputCharging; endproperty
  a_in_sleep: assert property (p_in_sleep) else $error("input charge in sleep");
  property p_ref_len;
    $fell(refCharging) && awakeNSleep |-> refCnt + 1 >= lim(refCode, REF_CYC0, REF_CYC1,
      REF_CYC2, REF_CYC3) && refCnt <= lim(refCode, REF_CYC0, REF_CYC1, REF_CYC2, REF_CYC3) + 1;
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("ref charge length wrong");
  property p_in_len;
    $fell(inputCharging) && awakeNSleep |-> inCnt + 1 >= lim(inCode, IN_CYC0, IN_CYC1,
      IN_CYC2, IN_CYC3) && inCnt <= lim(inCode, IN_CYC0, IN_CYC1, IN_CYC2, IN_CYC3) + 1;
  endproperty
  a_in_len: assert property (p_in_len) else $error("input charge length wrong");
  property p_ack;
    $rose(sdaOe) |-> !$past(scl, 1) && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5));
  endproperty
  a_ack: assert property (p_ack) else $error("data line driven off time");
endmodule // audio_adc_config_regs_low_asserts

bind audio_adc_config_regs_low audio_adc_config_regs_low_asserts #(.REF_CYC0(REF_CYC0),
  .REF_CYC1(REF_CYC1), .REF_CYC2(REF_CYC2), .REF_CYC3(REF_CYC3), .IN_CYC0(IN_CYC0),
  .IN_CYC1(IN_CYC1), .IN_CYC2(IN_CYC2), .IN_CYC3(IN_CYC3)) chk (.*);

// ==== i2c_host_model.sv ====
`timescale 1ns/100ps

module i2c_host_model #(
  parameter logic [6:0] DEV = 7'h4e
) (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Long phases so an ACK still held low never turns into a stop
  task automatic start();
    #100 sdaLow = 1'b0;
    #100 scl = 1'b1;
    #100 sdaLow = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic stop();
    #100 sdaLow = 1'b1;
    #100 scl = 1'b1;
    #100 sdaLow = 1'b0;
    #100;
  endtask
  task automatic sendBit(input logic b);
    #50 sdaLow = ~b;
    #50 scl = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic getBit(output logic b);
    #50 sdaLow = 1'b0;
    #50 scl = 1'b1;
    #75 b = sdaLine;
    #25 scl = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) sendBit(v[i]);
    getBit(ack);
    ack = ~ack;
  endtask
  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    start();
    sendByte({dev, 1'b0}, a0);
    sendByte(ra, a1);
    sendByte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic readReg(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    start();
    sendByte({DEV, 1'b0}, a);
    sendByte(ra, a);
    start();
    sendByte({DEV, 1'b1}, a);
    for (int i = 7; i >= 0; i--) getBit(d[i]);
    sendBit(1'b1);
    stop();
  endtask
endmodule // i2c_host_model

// ==== tb_top.sv ====
`timescale 1ns/100ps

`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failCount++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  localparam logic [6:0] DEV = 7'h4e; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, softResetPulse, analogSupplySource, broadcastEnable;
  logic awakeNSleep, refCharging, inputCharging, frameSyncInvert, bitClockInvert;
  logic txLateEdge, txIdleHiZ, lsbHalfCycle, daisyChain, busErrorDetectOff;
  logic faultResumeOff, inputMixInvert;
  logic [7:0] pageSelect;
  logic [4:0] msbOffset;
  logic [1:0] refChargeTime, inputCapChargeTime, frameFormat, slotWordLength, keeperMode;
  logic [1:0] mixSelect, mixAttenuation;
  int failCount = 0;
  int nCompared = 0;
  int pulses = 0;
  // Open drain with pull-up: either side may only pull low
  wire logic sdaIn = (sdaOe ? sdaOut : 1'b1) && !sdaLow;
  wire logic [7:0] fmtBits = {frameFormat, slotWordLength, frameSyncInvert, bitClockInvert,
    txLateEdge, txIdleHiZ};
  wire logic [7:0] outBits = {lsbHalfCycle, keeperMode, msbOffset};
  wire logic [4:0] mixBits = {mixSelect, mixAttenuation, inputMixInvert};
  wire logic [4:0] slpBits = {analogSupplySource, refChargeTime, broadcastEnable, awakeNSleep};

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (softResetPulse === 1'b1) pulses++;

  // Only the charge codes that the scenarios wake with are shortened
  audio_adc_config_regs_low #(.TARGET_ADDR(DEV), .REF_CYC1(40), .REF_CYC3(600), .IN_CYC1(50),
    .IN_CYC3(700)) uut (.*);
  i2c_host_model #(.DEV(DEV)) host (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaIn));

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    host.writeReg(DEV, ra, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    logic [7:0] d;
    host.readReg(ra, d);
    `CHK(d, e)
  endtask
  task automatic checkDefaults();
    logic [7:0] a [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a};
    logic [7:0] v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h30, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd(a[i], v[i]);
    `CHK(pageSelect, 8'h00)
    `CHK(({refCharging, inputCharging, daisyChain, sdaOut, sdaOe}), 5'b00000)
  endtask
  task automatic fieldScenario();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {2'(i % 3), 2'(i), 4'(1 << i)};
      wr(8'h07, v);
      rd(8'h07, v);
      `CHK(fmtBits, v)
      v = {i[0], 2'(i), 5'(i * 10 + 1)};
      wr(8'h08, v);
      `CHK(outBits, v)
      wr(8'h09, {2'b00, 2'(i), 4'h0});
      `CHK(({busErrorDetectOff, faultResumeOff}), 2'(i))
      wr(8'h0a, {2'(i), 2'(3 - i), i[0], 3'b000});
      `CHK(mixBits, ({2'(i), 2'(3 - i), i[0]}))
    end
    wr(8'h05, 8'h25);
    `CHK(inputCapChargeTime, 2'b10)
    wr(8'h02, 8'h9c);
    `CHK(slpBits, 5'b11110)
  endtask
  task automatic pageScenario();
    wr(8'h07, 8'h24);
    wr(8'h00, 8'h03);
    `CHK(pageSelect, 8'h03)
    wr(8'h07, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h00, 8'hff);
    `CHK(pageSelect, 8'hff)
    wr(8'h00, 8'h00);
    rd(8'h07, 8'h24);
  endtask
  task automatic broadcastScenario();
    logic ok;
    wr(8'h02, 8'h00);
    host.writeReg(7'h4c, 8'h08, 8'h11, ok);
    `CHK(ok, 1'b0)
    wr(8'h02, 8'h04);
    host.writeReg(7'h4c, 8'h08, 8'h11, ok);
    `CHK(ok, 1'b1)
    rd(8'h08, 8'h11);
    host.writeReg(7'h11, 8'h08, 8'h22, ok);
    `CHK(ok, 1'b0)
  endtask
  task automatic daisyScenario();
    wr(8'h0a, 8'h00);
    wr(8'h09, 8'h80);
    `CHK(daisyChain, 1'b1)
    wr(8'h0a, 8'h40);
    `CHK(daisyChain, 1'b0)
    rd(8'h09, 8'h80);
    wr(8'h09, 8'h00);
  endtask
  task automatic chargeScenario();
    int rc, ic;
    rc = 0;
    ic = 0;
    wr(8'h05, 8'h15);
    fork
      wr(8'h02, 8'h09);
      repeat (400) begin
        @(negedge sys_clk);
        rc += int'(refCharging === 1'b1);
        ic += int'(inputCharging === 1'b1);
      end
    join
    `CHK((rc inside {[39:41]}), 1'b1)
    `CHK((ic inside {[49:51]}), 1'b1)
    wr(8'h02, 8'h18);
    wr(8'h05, 8'h35);
    wr(8'h02, 8'h19);
    `CHK(({refCharging, inputCharging}), 2'b11)
    wr(8'h02, 8'h18);
    `CHK(({refCharging, inputCharging}), 2'b00)
  endtask
  task automatic maskScenario();
    logic [7:0] a [5] = '{8'h02, 8'h05, 8'h09, 8'h0a, 8'h03};
    logic [7:0] m [5] = '{8'h9c, 8'h35, 8'h30, 8'hf8, 8'h00};
    // Reserved bits carry defaults only; the chain bit is written as zero while mixing is on
    for (int i = 0; i < 5; i++) begin
      wr(a[i], m[i]);
      rd(a[i], m[i]);
    end
  endtask
  task automatic softResetScenario();
    wr(8'h07, 8'h12);
    pulses = 0;
    wr(8'h01, 8'h01);
    `CHK(pulses, 32'sd1)
    checkDefaults();
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    checkDefaults();
    fieldScenario();
    pageScenario();
    broadcastScenario();
    daisyScenario();
    chargeScenario();
    maskScenario();
    softResetScenario();
    conclude();
  end
  // Run needs well under a millisecond of link traffic
  initial begin
    #1500000;
    failCount++;
    conclude();
  end
endmodule // tb_top
